// file: core/fcc_fault_collector.sv
// Fault collector: per-source reactions, error pins, supervisor
`timescale 1ns/1ps
module fcc_fault_collector #(
  parameter int NHW       = fcc_pkg::NHW_DEF,
  parameter int RC_DIV    = fcc_pkg::RC_DIV_DEF,
  parameter int CFG_LIMIT = fcc_pkg::CFG_LIMIT_RC,
  parameter int N         = NHW + fcc_pkg::STC_W + 1,
  parameter int IDX_W     = $clog2(N)
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  input  wire logic [NHW-1:0]             i_hw_fault,
  input  wire fcc_pkg::fcc_stc_s          i_stc,
  input  wire fcc_pkg::fcc_temp_s         i_temp_a,
  input  wire fcc_pkg::fcc_temp_s         i_temp_b,
  input  wire logic                       i_temp_det_en,
  input  wire logic                       i_cfg_enter,
  input  wire logic                       i_cfg_leave,
  input  wire logic                       i_cfg_we,
  input  wire logic [IDX_W-1:0]           i_cfg_idx,
  input  wire logic [fcc_pkg::REACT_W-1:0] i_cfg_react,
  input  wire logic                       i_clear_we,
  input  wire logic [N-1:0]               i_clear_mask,
  output logic [1:0]                      o_state,
  output logic [N-1:0]                    o_status,
  output logic [fcc_pkg::TEMP_W-1:0]      o_temp_flags,
  output logic                            o_irq,
  output logic                            o_nmi,
  output logic                            o_reset_req,
  output logic                            o_fault_out_zero_o,
  output logic                            o_fault_out_zero_oe,
  output logic                            o_fault_out_one_o,
  output logic                            o_fault_out_one_oe
);

  // ==========================================================================
  // Declarations
  localparam int TEMP_IDX = NHW + fcc_pkg::STC_W;

  fcc_pkg::fcc_state_e              state;
  fcc_pkg::fcc_state_e              next_state;
  logic [fcc_pkg::REACT_W-1:0]      react [N];
  logic [fcc_pkg::TEMP_W-1:0]       temp_meta;
  logic [fcc_pkg::TEMP_W-1:0]       temp_sync;
  logic [N-1:0]                     fault_in;
  logic [N-1:0]                     status;
  logic [N-1:0]                     clr;
  logic                             temp_fault;
  logic                             active;
  logic                             live;
  logic                             want_irq;
  logic                             want_nmi;
  logic                             want_rst;
  logic                             want_ext;
  logic                             ext_active;
  logic                             sup_reset;

  function automatic logic any_react(input logic [N-1:0] st,
                                     input logic [fcc_pkg::REACT_W-1:0] code);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < N; k++) begin
      if (st[k] && react[k] == code) begin
        hit = 1'b1;
      end
    end
    return hit;
  endfunction

  // ==========================================================================
  // Temperature flags, two sensor sites, synchronised
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      temp_meta <= 6'h00;
      temp_sync <= 6'h00;
    end else begin
      temp_meta <= {i_temp_a, i_temp_b};
      temp_sync <= temp_meta;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_temp_flags <= 6'h00;
    end else begin
      o_temp_flags <= i_temp_det_en ? temp_sync : 6'h00;
    end
  end

  assign temp_fault = i_temp_det_en && (|temp_sync);

  // ==========================================================================
  // Fault source map
  assign fault_in = {temp_fault, i_stc, i_hw_fault};
  assign clr      = i_clear_we ? i_clear_mask : '0;

  // ==========================================================================
  // Per-source status and reaction settings
  generate
    for (genvar g = 0; g < N; g++) begin : g_src
      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          status[g] <= 1'b0;
        end else begin
          status[g] <= (status[g] & ~clr[g]) | fault_in[g];
        end
      end

      always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
          react[g] <= fcc_pkg::FCC_R_NONE;
        end else if (i_cfg_we && state == fcc_pkg::FCC_ST_CONFIG
                     && i_cfg_idx == IDX_W'(g)) begin
          react[g] <= i_cfg_react;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_status <= '0;
    end else begin
      o_status <= status;
    end
  end

  // ==========================================================================
  // State machine
  always_comb begin
    active = 1'b0;
    for (int k = 0; k < N; k++) begin
      if (status[k] && react[k] != fcc_pkg::FCC_R_NONE) begin
        active = 1'b1;
      end
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      fcc_pkg::FCC_ST_NORMAL: begin
        if (i_cfg_enter) begin
          next_state = fcc_pkg::FCC_ST_CONFIG;
        end else if (active) begin
          next_state = fcc_pkg::FCC_ST_FAULT;
        end
      end
      fcc_pkg::FCC_ST_CONFIG: begin
        if (i_cfg_leave) begin
          next_state = fcc_pkg::FCC_ST_NORMAL;
        end
      end
      fcc_pkg::FCC_ST_FAULT: begin
        if (!active) begin
          next_state = fcc_pkg::FCC_ST_NORMAL;
        end
      end
      default: begin
        next_state = fcc_pkg::FCC_ST_NORMAL;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= fcc_pkg::FCC_ST_NORMAL;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_state <= 2'h0;
    end else begin
      o_state <= next_state;
    end
  end

  // ==========================================================================
  // Reactions, no processor in the path
  always_comb begin
    live     = state != fcc_pkg::FCC_ST_CONFIG;
    want_irq = live && any_react(status, fcc_pkg::FCC_R_IRQ);
    want_nmi = live && any_react(status, fcc_pkg::FCC_R_NMI);
    want_rst = live && any_react(status, fcc_pkg::FCC_R_RESET);
    want_ext = live && any_react(status, fcc_pkg::FCC_R_EXT);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq       <= 1'b0;
      o_nmi       <= 1'b0;
      o_reset_req <= 1'b0;
      ext_active  <= 1'b0;
    end else begin
      o_irq       <= want_irq;
      o_nmi       <= want_nmi;
      o_reset_req <= want_rst | sup_reset;
      ext_active  <= want_ext;
    end
  end

  // ==========================================================================
  // Error pins: released during reset, driven afterwards
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_fault_out_zero_oe <= 1'b0;
      o_fault_out_one_oe  <= 1'b0;
      o_fault_out_zero_o  <= 1'b0;
      o_fault_out_one_o   <= 1'b0;
    end else begin
      o_fault_out_zero_oe <= 1'b1;
      o_fault_out_one_oe  <= 1'b1;
      o_fault_out_zero_o  <= ~ext_active;
      o_fault_out_one_o   <= ext_active;
    end
  end

  // ==========================================================================
  // Supervisor
  fcc_output_supervisor #(
    .RC_DIV     (RC_DIV),
    .CFG_LIMIT  (CFG_LIMIT),
    .RESP_LIMIT (fcc_pkg::RESP_LIMIT)
  ) u_sup (
    .i_clk           (i_clk),
    .i_rst           (i_rst),
    .i_in_config     (state == fcc_pkg::FCC_ST_CONFIG),
    .i_fault_pending (live && active),
    .i_reacted       (o_irq | o_nmi | o_reset_req | ext_active),
    .o_sup_reset     (sup_reset)
  );

  // ==========================================================================
  // Checks
  chk_fault_latch: assert property (@(posedge i_clk) disable iff (i_rst)
    fault_in[0] |=> status[0])
    else $error("fault input not latched");
  chk_status_sticky: assert property (@(posedge i_clk) disable iff (i_rst)
    status[1] && !clr[1] |=> status[1])
    else $error("status dropped without clear");
  chk_cfg_lock: assert property (@(posedge i_clk) disable iff (i_rst)
    state != fcc_pkg::FCC_ST_CONFIG |=> $stable(react[0]))
    else $error("reaction changed outside config");
  chk_enter_fault: assert property (@(posedge i_clk) disable iff (i_rst)
    state == fcc_pkg::FCC_ST_NORMAL && !i_cfg_enter && active
    |=> state == fcc_pkg::FCC_ST_FAULT)
    else $error("fault state not entered");
  chk_clear_normal: assert property (@(posedge i_clk) disable iff (i_rst)
    state == fcc_pkg::FCC_ST_FAULT && !active |=> state == fcc_pkg::FCC_ST_NORMAL)
    else $error("no return to normal");
  chk_irq_react: assert property (@(posedge i_clk) disable iff (i_rst)
    want_irq |=> o_irq)
    else $error("interrupt reaction missing");
  chk_pin_pair: assert property (@(posedge i_clk) disable iff (i_rst)
    o_fault_out_zero_oe |-> o_fault_out_zero_o != o_fault_out_one_o)
    else $error("error pins not complementary");
  chk_pin_drive: assert property (@(posedge i_clk) disable iff (i_rst)
    !$past(i_rst) |-> o_fault_out_zero_oe && o_fault_out_one_oe)
    else $error("error pins not driven");
  chk_ext_report: assert property (@(posedge i_clk) disable iff (i_rst)
    want_ext |=> ##1 o_fault_out_one_o)
    else $error("external report missing");
  chk_temp_fault: assert property (@(posedge i_clk) disable iff (i_rst)
    temp_fault |=> status[TEMP_IDX])
    else $error("temperature fault lost");
  chk_hw_forward: assert property (@(posedge i_clk) disable iff (i_rst)
    fault_in[NHW-1] |=> status[NHW-1])
    else $error("checker fault not latched");
  chk_stc_logic: assert property (@(posedge i_clk) disable iff (i_rst)
    i_stc.logic_fail |=> status[NHW+2])
    else $error("logic self-test failure lost");
  chk_stc_mem: assert property (@(posedge i_clk) disable iff (i_rst)
    i_stc.mem_fail |=> status[NHW+1])
    else $error("memory self-test failure lost");
  chk_stc_internal: assert property (@(posedge i_clk) disable iff (i_rst)
    i_stc.internal_err |=> status[NHW])
    else $error("self-test internal error lost");
  chk_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
    fault_in[2] && clr[2] |=> status[2])
    else $error("clear beat a new fault");
  chk_nmi_react: assert property (@(posedge i_clk) disable iff (i_rst)
    want_nmi |=> o_nmi)
    else $error("nmi reaction missing");
  chk_rst_react: assert property (@(posedge i_clk) disable iff (i_rst)
    want_rst |=> o_reset_req)
    else $error("reset reaction missing");
  chk_cfg_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    state == fcc_pkg::FCC_ST_CONFIG |=> !o_irq && !o_nmi)
    else $error("interrupt raised in config state");
  chk_temp_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_temp_det_en |=> o_temp_flags == '0)
    else $error("temperature flags not gated");
  chk_zero_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    !ext_active |=> o_fault_out_zero_o)
    else $error("zero pin low without fault");

endmodule

// file: core/fcc_pkg.sv
// Shared constants and types for the fault collection block
package fcc_pkg;

  // ==========================================================================
  // Reactions and states
  localparam int REACT_W = 3;

  typedef enum logic [2:0] {
    FCC_R_NONE  = 3'h0,
    FCC_R_IRQ   = 3'h1,
    FCC_R_NMI   = 3'h2,
    FCC_R_RESET = 3'h3,
    FCC_R_EXT   = 3'h4
  } fcc_react_e;

  typedef enum logic [1:0] {
    FCC_ST_NORMAL = 2'h0,
    FCC_ST_CONFIG = 2'h1,
    FCC_ST_FAULT  = 2'h2
  } fcc_state_e;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic low;
    logic high_a;
    logic high_b;
  } fcc_temp_s;

  typedef struct packed {
    logic logic_fail;
    logic mem_fail;
    logic internal_err;
  } fcc_stc_s;

  // ==========================================================================
  // Sizes and timing
  localparam int NHW_DEF      = 4;
  localparam int STC_W        = 3;
  localparam int TEMP_W       = 6;
  localparam int CFG_LIMIT_RC = 8000;
  localparam int RC_DIV_DEF   = 4;
  localparam int RESP_LIMIT   = 16;

endpackage

// file: core/fcc_output_supervisor.sv
// Output supervisor: config-time limit and missing-reaction watchdog
`timescale 1ns/1ps
module fcc_output_supervisor #(
  parameter int RC_DIV     = fcc_pkg::RC_DIV_DEF,
  parameter int CFG_LIMIT  = fcc_pkg::CFG_LIMIT_RC,
  parameter int RESP_LIMIT = fcc_pkg::RESP_LIMIT
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_in_config,
  input  wire logic i_fault_pending,
  input  wire logic i_reacted,
  output logic      o_sup_reset
);

  // ==========================================================================
  // Internal oscillator tick
  logic [15:0] rc_div;
  logic        rc_tick;
  logic [15:0] cfg_cnt;
  logic [15:0] resp_cnt;
  logic        cfg_expired;
  logic        resp_expired;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rc_div  <= 16'h0000;
      rc_tick <= 1'b0;
    end else if (rc_div == 16'(RC_DIV - 1)) begin
      rc_div  <= 16'h0000;
      rc_tick <= 1'b1;
    end else begin
      rc_div  <= rc_div + 16'h0001;
      rc_tick <= 1'b0;
    end
  end

  // ==========================================================================
  // Configuration time limit, fixed
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_cnt     <= 16'h0000;
      cfg_expired <= 1'b0;
    end else if (!i_in_config) begin
      cfg_cnt <= 16'h0000;
    end else if (rc_tick) begin
      if (cfg_cnt == 16'(CFG_LIMIT - 1)) begin
        cfg_expired <= 1'b1;
      end else begin
        cfg_cnt <= cfg_cnt + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Reaction watchdog
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      resp_cnt     <= 16'h0000;
      resp_expired <= 1'b0;
    end else if (!i_fault_pending || i_reacted) begin
      resp_cnt <= 16'h0000;
    end else if (resp_cnt == 16'(RESP_LIMIT - 1)) begin
      resp_expired <= 1'b1;
    end else begin
      resp_cnt <= resp_cnt + 16'h0001;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_sup_reset <= 1'b0;
    end else begin
      o_sup_reset <= o_sup_reset | cfg_expired | resp_expired;
    end
  end

  // ==========================================================================
  // Checks
  chk_cfg_count_bound: assert property (@(posedge i_clk) disable iff (i_rst)
    cfg_cnt < 16'(CFG_LIMIT))
    else $error("config counter passed limit");
  chk_sup_cause: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_sup_reset) |-> $past(cfg_expired) || $past(resp_expired))
    else $error("supervisor reset without cause");
  chk_resp_quiet: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reacted |=> resp_cnt == 16'h0000)
    else $error("watchdog ran despite reaction");

endmodule

// file: testbench/fcc_ext_monitor.sv
// External safety monitor model that watches the two fault pins
`timescale 1ns/1ps
module fcc_ext_monitor (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_zero_pin,
  input  wire logic i_one_pin,
  output logic      o_safe
);
  // ==========================================================================
  // Safe state entered on any failure indication, then held
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_safe <= 1'b0;
    end else if (!i_zero_pin || i_one_pin) begin
      o_safe <= 1'b1;
    end
  end
endmodule

// file: testbench/tb_top.sv
// Self-checking testbench for the fault collector
`timescale 1ns/1ps
module tb_top;
  // ==========================================================================
  // Signals
  logic                    i_clk;
  logic                    i_rst;
  logic [3:0]              i_hw_fault;
  fcc_pkg::fcc_stc_s       i_stc;
  fcc_pkg::fcc_temp_s      i_temp_a;
  fcc_pkg::fcc_temp_s      i_temp_b;
  logic                    i_temp_det_en;
  logic                    i_cfg_enter;
  logic                    i_cfg_leave;
  logic                    i_cfg_we;
  logic [2:0]              i_cfg_idx;
  logic [2:0]              i_cfg_react;
  logic                    i_clear_we;
  logic [7:0]              i_clear_mask;
  logic [1:0]              o_state;
  logic [7:0]              o_status;
  logic [5:0]              o_temp_flags;
  logic                    o_irq;
  logic                    o_nmi;
  logic                    o_reset_req;
  logic                    z_o;
  logic                    z_oe;
  logic                    one_o;
  logic                    one_oe;
  logic                    zero_pin;
  logic                    one_pin;
  logic                    safe;
  logic                    ext_seen;
  int                      fails;
  int                      num_checks;
  int                      tab [8] = '{0, 1, 2, 3, 4, 1, 2, 4};

  // Pins: pull-up on zero pin, pull-down on one pin
  assign zero_pin = z_oe ? z_o : 1'b1;
  assign one_pin  = one_oe ? one_o : 1'b0;

  fcc_fault_collector #(.NHW(4), .RC_DIV(2), .CFG_LIMIT(20)) dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_hw_fault(i_hw_fault), .i_stc(i_stc),
    .i_temp_a(i_temp_a), .i_temp_b(i_temp_b), .i_temp_det_en(i_temp_det_en),
    .i_cfg_enter(i_cfg_enter), .i_cfg_leave(i_cfg_leave), .i_cfg_we(i_cfg_we),
    .i_cfg_idx(i_cfg_idx), .i_cfg_react(i_cfg_react), .i_clear_we(i_clear_we),
    .i_clear_mask(i_clear_mask), .o_state(o_state), .o_status(o_status),
    .o_temp_flags(o_temp_flags), .o_irq(o_irq), .o_nmi(o_nmi),
    .o_reset_req(o_reset_req), .o_fault_out_zero_o(z_o), .o_fault_out_zero_oe(z_oe),
    .o_fault_out_one_o(one_o), .o_fault_out_one_oe(one_oe));

  fcc_ext_monitor mon (.i_clk(i_clk), .i_rst(i_rst), .i_zero_pin(zero_pin),
    .i_one_pin(one_pin), .o_safe(safe));

  // ==========================================================================
  // Clock and watchdog
  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  initial begin
    #(25 * 2000);
    fails++;
    summarize();
  end

  // ==========================================================================
  // Tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  task automatic cfg_write(input int idx, input int r);
    i_cfg_we    = 1'b1;
    i_cfg_idx   = idx[2:0];
    i_cfg_react = r[2:0];
    cyc(1);
    i_cfg_we    = 1'b0;
    cyc(1);
  endtask

  task automatic fault(input int i);
    case (i)
      4: i_stc.internal_err = 1'b1;
      5: i_stc.mem_fail = 1'b1;
      6: i_stc.logic_fail = 1'b1;
      7: i_temp_b.low = 1'b1;
      default: i_hw_fault[i[1:0]] = 1'b1;
    endcase
    cyc(1);
    i_hw_fault = 4'h0;
    i_stc      = 3'h0;
    i_temp_b   = 3'h0;
  endtask

  task automatic clear_all;
    i_clear_we   = 1'b1;
    i_clear_mask = 8'hff;
    cyc(1);
    i_clear_we   = 1'b0;
    cyc(3);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    {i_hw_fault, i_stc, i_temp_a, i_temp_b, i_temp_det_en} = '0;
    {i_cfg_enter, i_cfg_leave, i_cfg_we, i_cfg_idx, i_cfg_react} = '0;
    {i_clear_we, i_clear_mask} = '0;
    fails      = 0;
    num_checks = 0;
    ext_seen   = 1'b0;
    i_rst      = 1'b1;
    cyc(1);
    chk("oe_zero_rst", z_oe, 1'b0);
    chk("oe_one_rst", one_oe, 1'b0);
    cyc(1);
    i_rst = 1'b0;
    cyc(1);
    chk("pins_idle", {z_oe, one_oe, z_o, one_o}, 4'hE);
    i_cfg_enter = 1'b1;
    cyc(1);
    i_cfg_enter = 1'b0;
    cyc(1);
    chk("state_cfg", o_state, 2'h1);
    for (int i = 0; i < 8; i++) begin
      cfg_write(i, tab[i]);
    end
    i_cfg_leave = 1'b1;
    cyc(1);
    i_cfg_leave = 1'b0;
    cyc(1);
    chk("state_norm", o_state, 2'h0);
    cfg_write(0, 1);
    i_temp_det_en = 1'b1;
    for (int i = 0; i < 8; i++) begin
      fault(i);
      cyc(5);
      ext_seen = ext_seen | (tab[i] == 4);
      chk("status", o_status, 8'h01 << i);
      chk("state", o_state, (tab[i] == 0) ? 2'h0 : 2'h2);
      chk("irq", o_irq, tab[i] == 1);
      chk("nmi", o_nmi, tab[i] == 2);
      chk("reset_req", o_reset_req, tab[i] == 3);
      chk("one_pin", one_pin, tab[i] == 4);
      chk("zero_pin", zero_pin, tab[i] != 4);
      chk("monitor", safe, ext_seen);
      clear_all();
      chk("status_clr", o_status, 8'h00);
      chk("outs_clr", {o_state, o_irq, o_nmi, o_reset_req, one_pin}, 6'h00);
    end
    i_temp_det_en = 1'b0;
    i_temp_a      = 3'h5;
    i_temp_b      = 3'h2;
    cyc(5);
    chk("tflags_off", o_temp_flags, 6'h00);
    chk("tstat_off", o_status[7], 1'b0);
    i_temp_det_en = 1'b1;
    cyc(5);
    chk("tflags_on", o_temp_flags, 6'h2A);
    chk("tstat_on", o_status[7], 1'b1);
    i_temp_a = 3'h0;
    i_temp_b = 3'h0;
    cyc(3);
    clear_all();
    chk("tstat_clr", o_status, 8'h00);
    i_hw_fault   = 4'h4;
    i_clear_we   = 1'b1;
    i_clear_mask = 8'hff;
    cyc(1);
    i_hw_fault   = 4'h0;
    i_clear_we   = 1'b0;
    cyc(2);
    chk("set_wins", o_status[2], 1'b1);
    clear_all();
    chk("set_wins_clr", o_status, 8'h00);
    i_cfg_enter = 1'b1;
    cyc(1);
    i_cfg_enter = 1'b0;
    cyc(30);
    chk("sup_early", o_reset_req, 1'b0);
    cyc(20);
    chk("sup_late", o_reset_req, 1'b1);
    i_rst = 1'b1;
    cyc(1);
    chk("oe_rst2", {z_oe, one_oe, o_reset_req}, 3'h0);
    i_rst = 1'b0;
    cyc(2);
    chk("pins_idle2", {z_oe, one_oe, z_o, one_o, o_reset_req}, 5'h1C);
    summarize();
  end
endmodule
